// ==== hw/ifr_ctrl.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - force bits raise one request per level
// - level seven requests are never remapped
// - remap keeps vector, changes level and priority
// - slots give level six priority seven, six
// - reset clears both remap slots
// - six-bit slot field; invalid numbers ignored
// - forced requests fixed, not selectable by slots
// - wait wakeup path purely combinational
// - wakeup when enabled and level exceeds mask
// - wakeup mask level limited to six
// - wakeup control resets enabled, mask zero
// - enable bit seven, mask bits two-zero
// - set shortcut sets one mask bit
// - set-all bit sets every mask bit
// - mask shortcut reads end in error
// - shortcut indices 44 and up ignored
// - clear shortcut clears one or all
// - force set values 0x38-0x3e set bit
// - out-of-range force writes change nothing
// - force set reads end in error
// - undefined or unsupported accesses end in error
// - mask bit gates each peripheral request
// - force clear shortcut clears selected bit
module ifr_ctrl
	import ifr_pkg::*;
(
	input wire logic CLOCK_IN, // platform clock
	input wire logic RST_IN, // asynchronous reset, active high
	input wire logic BUS_SEL_IN, // byte access strobe
	input wire logic BUS_WR_IN, // 1 write, 0 read
	input wire logic [5:0] BUS_ADDR_IN, // byte offset in block
	input wire logic [7:0] BUS_WDATA_IN, // write data
	output logic [7:0] BUS_RDATA_OUT, // read data
	output logic BUS_ACK_OUT, // access done, one cycle
	output logic BUS_ERR_OUT, // bus error termination
	input wire logic [NUM_REQ-1:0] REQ_IN, // peripheral requests
	output logic [NUM_REQ-1:0] REQ_QUAL_OUT, // masked requests
	output logic [6:0] FORCE_REQ_OUT, // forced level requests, bit0 level 7
	output logic [NUM_REQ-1:0] REMAP_P7_OUT, // request promoted to l6p7
	output logic [NUM_REQ-1:0] REMAP_P6_OUT, // request promoted to l6p6
	output logic [2:0] REMAP_LEVEL_OUT, // level of remapped slots
	output logic [3:0] REMAP_P7_PRI_OUT, // priority of slot one
	output logic [3:0] REMAP_P6_PRI_OUT, // priority of slot two
	output logic [3:0] FORCE_PRI_OUT, // priority of forced requests
	input wire logic [NUM_REQ*3-1:0] REQ_LEVEL_IN, // fixed level per request
	output logic WAKEUP_OUT // wait mode wakeup to clock logic
);
	ifr_state_t st_reg, st_next;
	ifr_bus_t bus;
	logic [NUM_REQ-1:0] lvl_hit;
	logic [6:0] flvl_hit;

	// valid request index for the shortcuts
	function automatic logic idx_ok(input logic [5:0] v);
		return v < REQ_LIMIT;
	endfunction

	// valid slot number: peripheral, not level seven
	function automatic logic slot_ok(input logic [5:0] v);
		return (v < REQ_LIMIT) && (v >= 6'(NUM_FORCE_LEVEL_SEVEN_REQ));
	endfunction

	// force bit position from written value
	function automatic logic [6:0] force_sel(input logic [5:0] v);
		logic [6:0] r;
		r = 7'h00;
		if (v >= FORCE_LO && v <= FORCE_HI) begin
			r[3'(v - FORCE_LO)] = 1'b1;
		end
		return r;
	endfunction

	assign bus = '{sel: BUS_SEL_IN, wr: BUS_WR_IN, addr: BUS_ADDR_IN, wdata: BUS_WDATA_IN};

	// register next state and bus decode
	always_comb begin
		st_next = st_reg;
		st_next.ack = 1'b0;
		st_next.err = 1'b0;
		st_next.rdata = 8'h00;
		if (bus.sel) begin
			st_next.ack = 1'b1;
			unique case (bus.addr)
				OFS_MASK_HIGH, OFS_MASK_LOW: begin
					// full mask words are not held here; software uses the shortcuts
					st_next.err = 1'b1;
				end
				OFS_FORCE: begin
					if (bus.wr) st_next.force_lvl = bus.wdata[6:0];
					else st_next.rdata = {1'b0, st_reg.force_lvl};
				end
				OFS_REMAP_P7: begin
					if (bus.wr) st_next.remap_p7 = bus.wdata[5:0];
					else st_next.rdata = {2'b00, st_reg.remap_p7};
				end
				OFS_REMAP_P6: begin
					if (bus.wr) st_next.remap_p6 = bus.wdata[5:0];
					else st_next.rdata = {2'b00, st_reg.remap_p6};
				end
				OFS_WAKE: begin
					if (bus.wr) begin
						st_next.wake_enb = bus.wdata[WAKE_ENB_BIT];
						st_next.wake_mask = (bus.wdata[2:0] > WAKE_MASK_MAX) ?
							WAKE_MASK_MAX : bus.wdata[2:0];
					end else begin
						st_next.rdata = {st_reg.wake_enb, 4'h0, st_reg.wake_mask};
					end
				end
				OFS_MASK_SET: begin
					if (!bus.wr) st_next.err = 1'b1;
					else if (bus.wdata[IDX_ALL_BIT]) st_next.req_mask = '1;
					else if (idx_ok(bus.wdata[5:0]))
						st_next.req_mask[bus.wdata[5:0]] = 1'b1;
				end
				OFS_MASK_CLR: begin
					if (!bus.wr) st_next.err = 1'b1;
					else if (bus.wdata[IDX_ALL_BIT]) st_next.req_mask = '0;
					else if (idx_ok(bus.wdata[5:0]))
						st_next.req_mask[bus.wdata[5:0]] = 1'b0;
				end
				OFS_FORCE_SET: begin
					if (!bus.wr) st_next.err = 1'b1;
					else st_next.force_lvl = st_reg.force_lvl | force_sel(bus.wdata[5:0]);
				end
				OFS_FORCE_CLR: begin
					if (!bus.wr) st_next.err = 1'b1;
					else st_next.force_lvl = st_reg.force_lvl & ~force_sel(bus.wdata[5:0]);
				end
				default: st_next.err = 1'b1;
			endcase
		end
	end

	// state register
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			st_reg <= '0;
			st_reg.wake_enb <= WAKE_RESET[WAKE_ENB_BIT];
			st_reg.wake_mask <= WAKE_RESET[2:0];
		end else begin
			st_reg <= st_next;
		end
	end

	// request qualification and remap decode
	genvar gi;
	generate
		for (gi = 0; gi < NUM_REQ; gi++) begin : g_req
			assign REQ_QUAL_OUT[gi] = REQ_IN[gi] & ~st_reg.req_mask[gi];
			// promoted request keeps its own vector; only level and priority move
			assign REMAP_P7_OUT[gi] = slot_ok(st_reg.remap_p7) &&
				(st_reg.remap_p7 == 6'(gi));
			assign REMAP_P6_OUT[gi] = slot_ok(st_reg.remap_p6) &&
				(st_reg.remap_p6 == 6'(gi));
			// combinational wakeup compare, effective level includes remap
			assign lvl_hit[gi] = REQ_QUAL_OUT[gi] &&
				(((REMAP_P7_OUT[gi] | REMAP_P6_OUT[gi]) ? LVL_SIX :
				REQ_LEVEL_IN[gi*3 +: 3]) > st_reg.wake_mask);
		end
		for (gi = 0; gi < 7; gi++) begin : g_frc
			// bit 0 is level seven, bit 6 level one
			assign flvl_hit[gi] = st_reg.force_lvl[gi] && (3'(7 - gi) > st_reg.wake_mask);
		end
	endgenerate

	assign FORCE_REQ_OUT = st_reg.force_lvl;
	assign REMAP_LEVEL_OUT = LVL_SIX;
	assign REMAP_P7_PRI_OUT = PRI_SEVEN;
	assign REMAP_P6_PRI_OUT = PRI_SIX;
	assign FORCE_PRI_OUT = PRI_FORCE;
	assign WAKEUP_OUT = st_reg.wake_enb && ((|lvl_hit) || (|flvl_hit));
	assign BUS_RDATA_OUT = st_reg.rdata;
	assign BUS_ACK_OUT = st_reg.ack;
	assign BUS_ERR_OUT = st_reg.err;

	// assertions
	// an access is taken on one edge and answered on the next
	sequence s_access;
		bus.sel;
	endsequence

	sequence s_answer;
		BUS_ACK_OUT;
	endsequence

	sequence s_err_answer;
		BUS_ACK_OUT && BUS_ERR_OUT;
	endsequence

	sequence s_quiet;
		!BUS_ACK_OUT && !BUS_ERR_OUT;
	endsequence

	// bus handshake and error terminations
	a_access_answer: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_access |=> s_answer)
		else $error("access not answered");

	a_idle_quiet: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		!bus.sel |=> s_quiet)
		else $error("answer without access");

	a_undef_err: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_access ##0 (bus.addr > OFS_FORCE_CLR) |=> s_err_answer)
		else $error("undefined offset not errored");

	a_short_read_err: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_access ##0 (!bus.wr && (bus.addr == OFS_MASK_SET || bus.addr == OFS_MASK_CLR ||
		bus.addr == OFS_FORCE_SET)) |=> s_err_answer)
		else $error("shortcut read not errored");

	a_force_clr_read: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_access ##0 (!bus.wr && bus.addr == OFS_FORCE_CLR) |=> s_err_answer)
		else $error("force clear read not errored");

	// reset values
	a_slot_reset: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		$fell(RST_IN) |-> st_reg.remap_p7 == '0 && st_reg.remap_p6 == '0)
		else $error("remap slot not cleared by reset");

	a_wake_reset: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		$fell(RST_IN) |-> st_reg.wake_enb && st_reg.wake_mask == '0)
		else $error("wakeup control not at reset value");

	// wakeup control and comparator
	a_wake_mask_range: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		st_reg.wake_mask <= WAKE_MASK_MAX)
		else $error("wake mask above six");

	a_wake_sat: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_access ##0 (bus.wr && bus.addr == OFS_WAKE && bus.wdata[2:0] > WAKE_MASK_MAX)
		|=> st_reg.wake_mask == WAKE_MASK_MAX) else $error("wake mask not saturated");

	a_wake_disabled: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		!st_reg.wake_enb |-> !WAKEUP_OUT)
		else $error("wakeup while disabled");

	a_wake_forced: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		st_reg.wake_enb && st_reg.force_lvl[0] |-> WAKEUP_OUT)
		else $error("forced level seven did not wake");

	// mask shortcuts and request gating
	a_mask_set_one: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		bus.sel && bus.wr && bus.addr == OFS_MASK_SET && !bus.wdata[IDX_ALL_BIT] &&
		idx_ok(bus.wdata[5:0]) |=> st_reg.req_mask[$past(bus.wdata[5:0])])
		else $error("set shortcut missed");

	a_mask_set_all: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		bus.sel && bus.wr && bus.addr == OFS_MASK_SET && bus.wdata[IDX_ALL_BIT]
		|=> &st_reg.req_mask) else $error("set all missed");

	a_mask_clr_one: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		bus.sel && bus.wr && bus.addr == OFS_MASK_CLR && !bus.wdata[IDX_ALL_BIT] &&
		idx_ok(bus.wdata[5:0]) |=> !st_reg.req_mask[$past(bus.wdata[5:0])])
		else $error("clear shortcut missed");

	a_mask_clr_all: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		bus.sel && bus.wr && bus.addr == OFS_MASK_CLR && bus.wdata[IDX_ALL_BIT]
		|=> st_reg.req_mask == '0) else $error("clear all missed");

	a_mask_idx_skip: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_access ##0 (bus.wr && (bus.addr == OFS_MASK_SET || bus.addr == OFS_MASK_CLR) &&
		!bus.wdata[IDX_ALL_BIT] && !idx_ok(bus.wdata[5:0]))
		|=> $stable(st_reg.req_mask)) else $error("reserved mask index took effect");

	a_gate_masked: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		(REQ_QUAL_OUT & st_reg.req_mask) == '0)
		else $error("masked request passed");

	// force register and its shortcuts
	a_force_oor_hold: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		bus.sel && bus.wr && bus.addr == OFS_FORCE_SET &&
		(bus.wdata[5:0] < FORCE_LO || bus.wdata[5:0] > FORCE_HI)
		|=> $stable(st_reg.force_lvl)) else $error("force changed by bad value");

	a_force_set_hi: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		bus.sel && bus.wr && bus.addr == OFS_FORCE_SET && bus.wdata[5:0] == FORCE_HI
		|=> FORCE_REQ_OUT[6]) else $error("level one force missed");

	a_force_set_lo: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_access ##0 (bus.wr && bus.addr == OFS_FORCE_SET && bus.wdata[5:0] == FORCE_LO)
		|=> FORCE_REQ_OUT[0]) else $error("level seven force missed");

	a_force_clr_hit: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_access ##0 (bus.wr && bus.addr == OFS_FORCE_CLR && bus.wdata[5:0] >= FORCE_LO &&
		bus.wdata[5:0] <= FORCE_HI) |=> !FORCE_REQ_OUT[$past(bus.wdata[2:0])])
		else $error("force clear missed");

	a_force_clr_oor: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_access ##0 (bus.wr && bus.addr == OFS_FORCE_CLR &&
		(bus.wdata[5:0] < FORCE_LO || bus.wdata[5:0] > FORCE_HI))
		|=> $stable(st_reg.force_lvl)) else $error("force cleared by bad value");

	a_force_read_rsv: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_access ##0 (!bus.wr && bus.addr == OFS_FORCE) |=> BUS_RDATA_OUT < 8'h80)
		else $error("force reserved bit read as one");

	// remap slots
	a_remap_no_force_level_seven: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		REMAP_P7_OUT[NUM_FORCE_LEVEL_SEVEN_REQ-1:0] == '0 && REMAP_P6_OUT[NUM_FORCE_LEVEL_SEVEN_REQ-1:0] == '0)
		else $error("level seven request remapped");

	a_remap_onehot: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		$onehot0(REMAP_P7_OUT) && $onehot0(REMAP_P6_OUT))
		else $error("slot selects more than one request");

	a_remap_bad_slot: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		(slot_ok(st_reg.remap_p7) || REMAP_P7_OUT == '0) &&
		(slot_ok(st_reg.remap_p6) || REMAP_P6_OUT == '0))
		else $error("invalid slot number remapped");

	a_slot_read_rsv: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_access ##0 (!bus.wr && (bus.addr == OFS_REMAP_P7 || bus.addr == OFS_REMAP_P6))
		|=> BUS_RDATA_OUT < 8'h40) else $error("slot reserved bits read as one");
endmodule

// ==== pkg/ifr_pkg.sv ====
package ifr_pkg;
	// register byte offsets inside the 64-byte block
	localparam logic [5:0] OFS_MASK_HIGH = 6'h08;
	localparam logic [5:0] OFS_MASK_LOW = 6'h0c;
	localparam logic [5:0] OFS_FORCE = 6'h10;
	localparam logic [5:0] OFS_REMAP_P7 = 6'h18;
	localparam logic [5:0] OFS_REMAP_P6 = 6'h19;
	localparam logic [5:0] OFS_WAKE = 6'h1b;
	localparam logic [5:0] OFS_MASK_SET = 6'h1c;
	localparam logic [5:0] OFS_MASK_CLR = 6'h1d;
	localparam logic [5:0] OFS_FORCE_SET = 6'h1e;
	localparam logic [5:0] OFS_FORCE_CLR = 6'h1f;
	// request counts and field layout
	localparam int NUM_REQ = 44;
	localparam int NUM_FORCE_LEVEL_SEVEN_REQ = 4;
	localparam logic [5:0] REQ_LIMIT = 6'h2c;
	localparam int IDX_ALL_BIT = 6;
	localparam int WAKE_ENB_BIT = 7;
	localparam logic [5:0] FORCE_LO = 6'h38;
	localparam logic [5:0] FORCE_HI = 6'h3e;
	localparam logic [2:0] WAKE_MASK_MAX = 3'h6;
	localparam logic [7:0] WAKE_RESET = 8'h80;
	localparam logic [2:0] LVL_SIX = 3'h6;
	localparam logic [3:0] PRI_SEVEN = 4'h7;
	localparam logic [3:0] PRI_SIX = 4'h6;
	localparam logic [3:0] PRI_FORCE = 4'h0;

	// byte-wide bus request
	typedef struct packed {
		logic sel;
		logic wr;
		logic [5:0] addr;
		logic [7:0] wdata;
	} ifr_bus_t;

	// all register state of the block
	typedef struct packed {
		logic [NUM_REQ-1:0] req_mask;
		logic [6:0] force_lvl;
		logic [5:0] remap_p7;
		logic [5:0] remap_p6;
		logic wake_enb;
		logic [2:0] wake_mask;
		logic [7:0] rdata;
		logic ack;
		logic err;
	} ifr_state_t;
endpackage

// ==== test/ifr_ctrl_bench.sv ====
`timescale 1ns/1ps
module ifr_ctrl_bench import ifr_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sel = 1'b0;
	logic wr = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [7:0] wd = 8'h00;
	logic [NUM_REQ-1:0] rq = '0;
	logic [NUM_REQ*3-1:0] lvl;
	logic [7:0] rd;
	logic ack, err, wake;
	logic [NUM_REQ-1:0] qual, r7, r6;
	logic [6:0] frc;
	logic [2:0] rlvl;
	logic [3:0] p7, p6, pf;
	int n_fail = 0;
	int compares = 0;
	// 25 MHz platform clock
	always #20 clk = ~clk;
	ifr_src_model u_ifr_src_model (.REQ_LEVEL_OUT(lvl));
	ifr_ctrl u_ifr_ctrl (.CLOCK_IN(clk), .RST_IN(rst), .BUS_SEL_IN(sel), .BUS_WR_IN(wr),
		.BUS_ADDR_IN(addr), .BUS_WDATA_IN(wd), .BUS_RDATA_OUT(rd), .BUS_ACK_OUT(ack),
		.BUS_ERR_OUT(err), .REQ_IN(rq), .REQ_QUAL_OUT(qual), .FORCE_REQ_OUT(frc),
		.REMAP_P7_OUT(r7), .REMAP_P6_OUT(r6), .REMAP_LEVEL_OUT(rlvl), .REMAP_P7_PRI_OUT(p7),
		.REMAP_P6_PRI_OUT(p6), .FORCE_PRI_OUT(pf), .REQ_LEVEL_IN(lvl), .WAKEUP_OUT(wake));
	// compare and count
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// one byte access: strobe for one edge, bounded wait for ack, judge err and read data
	task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
		input logic [7:0] er, input logic ee);
		int k;
		sel = 1'b1;
		wr = w;
		addr = a;
		wd = d;
		@(negedge clk);
		sel = 1'b0;
		k = 0;
		while (ack !== 1'b1 && k < 4) begin
			@(negedge clk);
			k++;
		end
		if (k == 4) begin
			n_fail++;
			give_verdict();
		end
		check(err, ee);
		if (!w && !ee) begin
			check(rd, er);
		end
		@(negedge clk);
	endtask
	// change requests on a falling edge and let the combinational outputs settle
	task automatic req(input logic [NUM_REQ-1:0] v);
		rq = v;
		@(negedge clk);
	endtask
	task automatic t_reset();
		xfer(0, OFS_WAKE, 0, WAKE_RESET, 0);
		xfer(0, OFS_REMAP_P7, 0, 8'h00, 0);
		xfer(0, OFS_REMAP_P6, 0, 8'h00, 0);
		xfer(0, OFS_FORCE, 0, 8'h00, 0);
	endtask
	task automatic t_force();
		for (int v = 56; v < 63; v++) begin
			xfer(1, OFS_FORCE_SET, 8'(v), 0, 0);
			check(frc, 7'h7f >> (62 - v));
		end
		xfer(1, OFS_FORCE_SET, 8'h37, 0, 0);
		xfer(0, OFS_FORCE, 0, 8'h7f, 0);
		xfer(1, OFS_FORCE_CLR, 8'h3a, 0, 0);
		xfer(1, OFS_FORCE_SET, 8'h3f, 0, 0);
		xfer(1, OFS_FORCE_CLR, 8'h3f, 0, 0);
		check(frc, 7'h7b);
		xfer(1, OFS_FORCE, 8'hff, 0, 0);
		xfer(0, OFS_FORCE, 0, 8'h7f, 0);
		xfer(1, OFS_FORCE, 8'h00, 0, 0);
		check(frc, 7'h00);
		check(pf, PRI_FORCE);
	endtask
	task automatic t_errors();
		for (int a = 28; a < 32; a++)
			xfer(0, 6'(a), 0, 8'h00, 1);
		xfer(0, OFS_MASK_HIGH, 0, 8'h00, 1);
		xfer(1, 6'h3f, 8'h00, 0, 1);
	endtask
	task automatic t_mask();
		req({NUM_REQ{1'b1}});
		xfer(1, OFS_MASK_SET, 8'h05, 0, 0);
		check(qual, 44'(~(44'h1 << 5)));
		xfer(1, OFS_MASK_SET, 8'h2c, 0, 0);
		xfer(1, OFS_MASK_CLR, 8'h2d, 0, 0);
		check(qual, 44'(~(44'h1 << 5)));
		xfer(1, OFS_MASK_SET, 8'h45, 0, 0);
		check(qual, 44'h0);
		xfer(1, OFS_MASK_CLR, 8'h07, 0, 0);
		check(qual, 44'h1 << 7);
		xfer(1, OFS_MASK_CLR, 8'h47, 0, 0);
		check(qual, {NUM_REQ{1'b1}});
		req('0);
	endtask
	task automatic t_remap();
		xfer(1, OFS_REMAP_P7, 8'h05, 0, 0);
		check(r7, 44'h1 << 5);
		xfer(1, OFS_REMAP_P6, 8'h02, 0, 0);
		check(r6, 44'h0);
		xfer(1, OFS_REMAP_P6, 8'h2c, 0, 0);
		check(r6, 44'h0);
		xfer(1, OFS_REMAP_P6, 8'hc9, 0, 0);
		xfer(0, OFS_REMAP_P6, 0, 8'h09, 0);
		check(r6, 44'h1 << 9);
		check({rlvl, p7, p6}, {LVL_SIX, PRI_SEVEN, PRI_SIX});
	endtask
	task automatic t_wake();
		xfer(1, OFS_WAKE, 8'hff, 0, 0);
		xfer(0, OFS_WAKE, 0, 8'h86, 0);
		req(44'h1 << 4);
		check(wake, 1'b0);
		req(44'h1);
		check(wake, 1'b1);
		xfer(1, OFS_WAKE, 8'h05, 0, 0);
		check(wake, 1'b0);
		xfer(1, OFS_WAKE, 8'h85, 0, 0);
		req(44'h1 << 9);
		check(wake, 1'b1);
		req(44'h1 << 10);
		check(wake, 1'b0);
		xfer(1, OFS_FORCE_SET, 8'h3a, 0, 0);
		check(wake, 1'b0);
		xfer(1, OFS_FORCE_SET, 8'h38, 0, 0);
		check(wake, 1'b1);
		xfer(1, OFS_FORCE_CLR, 8'h38, 0, 0);
		check(wake, 1'b0);
		req('0);
	endtask
	// reset for three cycles, then the scenarios
	initial begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		t_reset();
		t_force();
		t_errors();
		t_mask();
		t_remap();
		t_wake();
		give_verdict();
	end
endmodule

// ==== test/ifr_src_model.sv ====
`timescale 1ns/1ps
// far side: fixed level of every peripheral request as the request sources are wired
module ifr_src_model
	import ifr_pkg::*;
(
	output logic [NUM_REQ*3-1:0] REQ_LEVEL_OUT // level per request
);
	// four level-seven sources, five at level six, then seven per level down to one
	always_comb begin
		for (int n = 0; n < NUM_REQ; n++) begin
			REQ_LEVEL_OUT[3*n+:3] = (n < 4) ? 3'h7 : (n < 9) ? 3'h6 : 3'(5 - (n - 9) / 7);
		end
	end
endmodule
